// >>> src/dac_update_ctrl.sv
// Purpose: Preload, update mode and clamp control of a multichannel card.
// Assumes: Host port cycles hold strobes for several system clocks.
// Notes: Reads are commands only; the card never drives the data bus.
`timescale 1ns/1ps
module dac_update_ctrl
   import dac_update_pkg::*;
(
   // Clock and reset.
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // Host port cycle pins.
   input wire logic IOR_N,
   input wire logic IOW_N,
   input wire logic SBHE_N,
   input wire logic [ADDR_W-1:0] SA,
   input wire logic [BUS_W-1:0] SD,
   // Board straps; a switch bit of one means the switch is ON.
   input wire logic [SW_W-1:0] BASE_ADDRESS_SWITCH_BANK,
   input wire logic BUILD_16CH,
   // Converter codes and status.
   output dac_word_t [NUM_CH-1:0] DAC_CODE,
   output logic OUTPUT_CLAMPED,
   output logic BROADCAST_MODE
);
   logic rst_meta_q, rst_n_q;
   isa_bus_t bus_s;
   strap_t strap_s;
   logic rd_prev_q, wr_prev_q, rd_prev_d, wr_prev_d;
   logic rd_evt, wr_evt, hit, rd_cmd, wr_acc, lo_wr, hi_wr, load_all;
   logic [OFF_W-1:0] off;
   logic [CH_W-1:0] ch;
   logic [HI_W-1:0] hi_nib;
   load_mode_t mode_q, mode_d;
   logic clamp_q, clamp_d;
   dac_word_t [NUM_CH-1:0] preload_q, preload_d;
   dac_word_t [NUM_CH-1:0] inner_q, inner_d;
   dac_word_t [NUM_CH-1:0] out_q, out_d;

   // Reset is released through two flip-flops.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   pin_sync #(.W($bits(isa_bus_t)), .IDLE(BUS_IDLE)) u_bus_sync (
      .clk(CLK_SYS),
      .rst_n(rst_n_q),
      .pin({IOR_N, IOW_N, SBHE_N, SA, SD}),
      .value(bus_s)
   );

   pin_sync #(.W($bits(strap_t)), .IDLE(STRAP_IDLE)) u_strap_sync (
      .clk(CLK_SYS),
      .rst_n(rst_n_q),
      .pin({BASE_ADDRESS_SWITCH_BANK, BUILD_16CH}),
      .value(strap_s)
   );

   function automatic logic base_match(input logic [ADDR_W-1:0] a,
                                       input strap_t st);
      logic ok;
      ok = st.build16 | ~a[NARROW_BIT];
      for (int i = 0; i < SW_W; i++) begin
         if (a[BASE_LSB+i] != ~st.sw_on[i]) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction : base_match

   function automatic logic is_off(input logic [OFF_W-1:0] o,
                                   input logic [OFF_W-1:0] k);
      return o == k;
   endfunction : is_off

   // Strobe edges are taken from the filtered pin copy.
   always_comb begin
      rd_prev_d = ~bus_s.ior_n;
      wr_prev_d = ~bus_s.iow_n;
   end

   always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rd_prev_q <= 1'b0;
         wr_prev_q <= 1'b0;
      end else begin
         rd_prev_q <= rd_prev_d;
         wr_prev_q <= wr_prev_d;
      end
   end

   assign rd_evt = ~bus_s.ior_n & ~rd_prev_q;
   assign wr_evt = ~bus_s.iow_n & ~wr_prev_q;
   assign hit = base_match(bus_s.addr, strap_s);
   assign off = bus_s.addr[OFF_W-1:0];
   assign ch = off[OFF_W-1:1];
   assign rd_cmd = rd_evt & hit;
   assign wr_acc = wr_evt & hit;
   assign lo_wr = wr_acc & ~off[0];
   assign hi_wr = wr_acc & (off[0] | ~bus_s.sbhe_n);
   assign hi_nib = off[0] ? bus_s.data[HI_W-1:0]
                          : bus_s.data[HI_LANE_LSB +: HI_W];

   // Mode and clamp commands.
   always_comb begin
      mode_d = mode_q;
      clamp_d = clamp_q;
      load_all = 1'b0;
      if (rd_cmd) begin
         case (off)
            OFF_BCAST_ENTER: begin
               mode_d = MODE_BCAST;
            end
            OFF_PERCH_ENTER: begin
               mode_d = MODE_PERCH;
            end
            OFF_LOAD_STAY: begin
               load_all = 1'b1;
               mode_d = MODE_BCAST;
            end
            OFF_LOAD_PERCH: begin
               load_all = 1'b1;
               mode_d = MODE_PERCH;
            end
            OFF_CLAMP_SET: begin
               clamp_d = 1'b1;
            end
            default: begin
               mode_d = mode_q;
            end
         endcase
      end
      if (wr_acc && is_off(off, OFF_CLAMP_CLR)) begin
         clamp_d = 1'b0;
         load_all = 1'b1;
      end
   end

   // Per-channel preload, inner and output registers.
   for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      always_comb begin
         preload_d[g] = preload_q[g];
         if (lo_wr && ch == CH_W'(g)) begin
            preload_d[g][LO_W-1:0] = bus_s.data[LO_W-1:0];
         end
         if (hi_wr && ch == CH_W'(g)) begin
            preload_d[g][LO_W +: HI_W] = hi_nib;
         end
         inner_d[g] = inner_q[g];
         if (load_all) begin
            inner_d[g] = preload_d[g];
         end else if (mode_q == MODE_PERCH && hi_wr && ch == CH_W'(g)) begin
            inner_d[g] = preload_d[g];
         end
         out_d[g] = clamp_d ? SAFE_CODE : inner_d[g];
      end
   end

   // Preload keeps its contents through reset.
   always_ff @(posedge CLK_SYS) begin
      preload_q <= preload_d;
   end

   always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mode_q <= MODE_BCAST;
         clamp_q <= 1'b1;
         inner_q <= {NUM_CH{SAFE_CODE}};
         out_q <= {NUM_CH{SAFE_CODE}};
      end else begin
         mode_q <= mode_d;
         clamp_q <= clamp_d;
         inner_q <= inner_d;
         out_q <= out_d;
      end
   end

   assign DAC_CODE = out_q;
   assign OUTPUT_CLAMPED = clamp_q;
   assign BROADCAST_MODE = (mode_q == MODE_BCAST);

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!rst_n_q);

   property p_clamp_set;
      rd_cmd && is_off(off, OFF_CLAMP_SET) |=>
         OUTPUT_CLAMPED && DAC_CODE == {NUM_CH{SAFE_CODE}}
         && $stable(mode_q) && $stable(inner_q);
   endproperty
   a_clamp_set: assert property (p_clamp_set)
      else $error("Clamp command did not clamp cleanly.");

   property p_clamp_clr;
      wr_acc && is_off(off, OFF_CLAMP_CLR) |=>
         !OUTPUT_CLAMPED && DAC_CODE == preload_q;
   endproperty
   a_clamp_clr: assert property (p_clamp_clr)
      else $error("Clamp release did not restore preload.");

   property p_perch_enter;
      rd_cmd && is_off(off, OFF_PERCH_ENTER) |=>
         !BROADCAST_MODE && $stable(inner_q);
   endproperty
   a_perch_enter: assert property (p_perch_enter)
      else $error("Read at two misbehaved.");

   property p_bcast_enter;
      rd_cmd && is_off(off, OFF_BCAST_ENTER) |=>
         BROADCAST_MODE && $stable(inner_q);
   endproperty
   a_bcast_enter: assert property (p_bcast_enter)
      else $error("Read at zero misbehaved.");

   property p_load_stay;
      rd_cmd && is_off(off, OFF_LOAD_STAY) |=>
         BROADCAST_MODE && inner_q == preload_q;
   endproperty
   a_load_stay: assert property (p_load_stay)
      else $error("Read at eight did not load all.");

   property p_load_perch;
      rd_cmd && is_off(off, OFF_LOAD_PERCH) |=>
         !BROADCAST_MODE && inner_q == preload_q;
   endproperty
   a_load_perch: assert property (p_load_perch)
      else $error("Read at ten did not load all.");

   property p_bcast_hold;
      mode_q == MODE_BCAST && !rd_cmd
         && !(wr_acc && is_off(off, OFF_CLAMP_CLR)) |=> $stable(inner_q);
   endproperty
   a_bcast_hold: assert property (p_bcast_hold)
      else $error("Output changed in broadcast mode.");

   property p_perch_xfer;
      mode_q == MODE_PERCH && hi_wr |=>
         inner_q[$past(ch)] == preload_q[$past(ch)];
   endproperty
   a_perch_xfer: assert property (p_perch_xfer)
      else $error("High byte write did not transfer.");

   property p_lo_only;
      lo_wr && bus_s.sbhe_n && !rd_cmd |=> $stable(inner_q);
   endproperty
   a_lo_only: assert property (p_lo_only)
      else $error("Low byte write moved an output.");

   property p_miss;
      (rd_evt || wr_evt) && !hit |=>
         $stable(mode_q) && $stable(clamp_q) && $stable(inner_q);
   endproperty
   a_miss: assert property (p_miss)
      else $error("Access outside the window had effect.");

   property p_reset;
      $rose(rst_n_q) |-> OUTPUT_CLAMPED && BROADCAST_MODE;
   endproperty
   a_reset: assert property (@(posedge CLK_SYS) p_reset)
      else $error("Reset state wrong.");

   property p_clamp_hold;
      OUTPUT_CLAMPED |-> DAC_CODE == {NUM_CH{SAFE_CODE}};
   endproperty
   a_clamp_hold: assert property (p_clamp_hold)
      else $error("Clamped output not at safe code.");

   property p_lo_byte;
      lo_wr |=>
         preload_q[$past(ch)][LO_W-1:0] == $past(bus_s.data[LO_W-1:0]);
   endproperty
   a_lo_byte: assert property (p_lo_byte)
      else $error("Low byte not stored.");

   property p_hi_nibble;
      hi_wr && off[0] |=>
         preload_q[$past(ch)][LO_W +: HI_W] == $past(bus_s.data[HI_W-1:0]);
   endproperty
   a_hi_nibble: assert property (p_hi_nibble)
      else $error("High byte nibble not stored.");

   // A word write takes its high nibble from the upper data lane.
   property p_word_nibble;
      hi_wr && !off[0] |=>
         preload_q[$past(ch)][LO_W +: HI_W]
         == $past(bus_s.data[HI_LANE_LSB +: HI_W]);
   endproperty
   a_word_nibble: assert property (p_word_nibble)
      else $error("Word write high nibble not stored.");
endmodule : dac_update_ctrl

// >>> src/dac_update_pkg.sv
// Purpose: Shared constants and types for the output card update control.
// Assumes: One system clock; host bus pins arrive asynchronously.
// Notes: Offsets are byte offsets inside the decoded window.
package dac_update_pkg;
   localparam int NUM_CH = 16;
   localparam int CH_W = 4;
   localparam int DATA_W = 12;
   localparam int ADDR_W = 10;
   localparam int OFF_W = 5;
   localparam int SW_W = 5;
   localparam int BASE_LSB = 5;
   localparam int BUS_W = 16;
   localparam int LO_W = 8;
   localparam int HI_W = 4;
   localparam int HI_LANE_LSB = 8;

   localparam logic [OFF_W-1:0] OFF_BCAST_ENTER = 5'h00;
   localparam logic [OFF_W-1:0] OFF_PERCH_ENTER = 5'h02;
   localparam logic [OFF_W-1:0] OFF_LOAD_STAY = 5'h08;
   localparam logic [OFF_W-1:0] OFF_LOAD_PERCH = 5'h0a;
   localparam logic [OFF_W-1:0] OFF_CLAMP_SET = 5'h0e;
   localparam logic [OFF_W-1:0] OFF_CLAMP_CLR = 5'h0f;
   localparam int NARROW_BIT = 4;

   typedef logic [DATA_W-1:0] dac_word_t;
   localparam dac_word_t SAFE_CODE = 12'h000;

   typedef enum logic {MODE_BCAST, MODE_PERCH} load_mode_t;

   typedef struct packed {
      logic ior_n;
      logic iow_n;
      logic sbhe_n;
      logic [ADDR_W-1:0] addr;
      logic [BUS_W-1:0] data;
   } isa_bus_t;

   typedef struct packed {
      logic [SW_W-1:0] sw_on;
      logic build16;
   } strap_t;

   localparam isa_bus_t BUS_IDLE = '{1'b1, 1'b1, 1'b1, 10'h000, 16'h0000};
   localparam strap_t STRAP_IDLE = '{5'h00, 1'b1};
endpackage : dac_update_pkg

// >>> src/pin_sync.sv
// Purpose: Three-stage synchroniser for asynchronous pin groups.
// Assumes: Reset is already synchronous to clk on release.
// Notes: The output changes only once stages two and three agree.
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] IDLE = '0
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Pins and filtered copy.
   input wire logic [W-1:0] pin,
   output logic [W-1:0] value
);
   logic [W-1:0] stg1_q, stg2_q, stg3_q, val_q, val_d;

   always_comb begin
      val_d = val_q;
      if (stg2_q == stg3_q) begin
         val_d = stg3_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stg1_q <= IDLE;
         stg2_q <= IDLE;
         stg3_q <= IDLE;
         val_q <= IDLE;
      end else begin
         stg1_q <= pin;
         stg2_q <= stg1_q;
         stg3_q <= stg2_q;
         val_q <= val_d;
      end
   end

   assign value = val_q;
endmodule : pin_sync

// >>> testbench/isa_host_model.sv
// Purpose: Behavioural host that runs port I/O cycles on the card.
// Assumes: The caller waits well past reset release before the first cycle.
// Notes: Pins change only at the falling clock edge.
`timescale 1ns/1ps
module isa_host_model
   import dac_update_pkg::*;
(
   // Clock.
   input wire logic clk,
   // Host pins.
   output isa_bus_t bus
);
   initial begin
      bus = BUS_IDLE;
   end

   // One port cycle; hold sets how many clocks the strobe stays low.
   task automatic cycle(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [BUS_W-1:0] d, input logic word,
                        input int hold);
      @(negedge clk);
      bus.addr = a;
      bus.data = d;
      bus.sbhe_n = ~word;
      repeat (4) @(negedge clk);
      if (wr) begin
         bus.iow_n = 1'b0;
      end else begin
         bus.ior_n = 1'b0;
      end
      repeat (hold) @(negedge clk);
      bus.iow_n = 1'b1;
      bus.ior_n = 1'b1;
      repeat (2) @(negedge clk);
      // Released data lines float and show the inverse of the last value.
      bus.data = ~d;
      bus.sbhe_n = 1'b1;
      repeat (6) @(negedge clk);
   endtask : cycle
endmodule : isa_host_model

// >>> testbench/testbench.sv
// Purpose: Self-checking bench for the output card update control.
// Assumes: Host cycles come from the behavioural host model.
// Notes: Expected outputs follow a preload and output model kept here.
`timescale 1ns/1ps
module testbench
   import dac_update_pkg::*;
;
   localparam logic [ADDR_W-1:0] BASE = 10'h300;
   logic clk;
   logic rst_n;
   isa_bus_t bus;
   strap_t st;
   dac_word_t [NUM_CH-1:0] code;
   logic clamped_o;
   logic bcast_o;
   dac_word_t pre [NUM_CH];
   dac_word_t shown [NUM_CH];
   logic bc;
   logic cl;
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;

   isa_host_model host (.clk(clk), .bus(bus));

   dac_update_ctrl DUT (
      .CLK_SYS(clk), .RST_N(rst_n), .IOR_N(bus.ior_n), .IOW_N(bus.iow_n),
      .SBHE_N(bus.sbhe_n), .SA(bus.addr), .SD(bus.data),
      .BASE_ADDRESS_SWITCH_BANK(st.sw_on), .BUILD_16CH(st.build16),
      .DAC_CODE(code), .OUTPUT_CLAMPED(clamped_o), .BROADCAST_MODE(bcast_o)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_all();
      for (int n = 0; n < NUM_CH; n++) begin
         chk(code[n], cl ? SAFE_CODE : shown[n]);
      end
      chk({11'h000, clamped_o}, {11'h000, cl});
      chk({11'h000, bcast_o}, {11'h000, bc});
   endtask : chk_all

   task automatic wrb(input int off, input logic [7:0] d);
      host.cycle(1'b1, BASE + 10'(off), {~d, d}, 1'b0, 8);
      if (off % 2 == 1) begin
         pre[off/2][11:8] = d[3:0];
         if (!bc) shown[off/2] = pre[off/2];
      end else begin
         pre[off/2][7:0] = d;
      end
      if (off == 15) begin
         cl = 1'b0;
         shown = pre;
      end
   endtask : wrb

   task automatic wrw(input int ch, input dac_word_t v);
      host.cycle(1'b1, BASE + 10'(2*ch), {4'ha, v}, 1'b1, 3);
      pre[ch] = v;
      if (!bc) shown[ch] = v;
   endtask : wrw

   task automatic rd(input int off);
      host.cycle(1'b0, BASE + 10'(off), 16'h0000, 1'b0, 8);
      case (off)
         0: bc = 1'b1;
         2: bc = 1'b0;
         8: begin
            shown = pre;
            bc = 1'b1;
         end
         10: begin
            shown = pre;
            bc = 1'b0;
         end
         14: cl = 1'b1;
         default: ;
      endcase
   endtask : rd

   task automatic do_reset();
      @(negedge clk);
      rst_n = 1'b0;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      repeat (8) @(negedge clk);
      bc = 1'b1;
      cl = 1'b1;
   endtask : do_reset

   task automatic done(input string name);
      $display("test %s done, errors so far %0d", name, num_errors);
   endtask : done

   task automatic t_fill();
      dac_word_t v;
      // Channel 7's high byte is the clamp release, so it goes as a word.
      for (int n = 0; n < NUM_CH; n++) begin
         v = dac_word_t'(12'h111 * n) ^ 12'h5a3;
         if (n % 4 == 1) begin
            wrb(2*n, v[7:0]);
            wrb(2*n+1, {4'hc, v[11:8]});
         end else begin
            wrw(n, v);
         end
      end
      chk_all();
      wrb(15, 8'h3b);
      chk_all();
      wrw(3, 12'h7e1);
      chk_all();
      rd(8);
      chk_all();
      done("fill");
   endtask : t_fill

   task automatic t_perch();
      rd(2);
      chk_all();
      wrb(8, 8'h44);
      chk_all();
      wrb(9, 8'hf2);
      chk_all();
      wrw(5, 12'h9c6);
      chk_all();
      rd(0);
      chk_all();
      wrw(6, 12'h123);
      chk_all();
      rd(10);
      chk_all();
      done("modes");
   endtask : t_perch

   task automatic t_clamp();
      rd(14);
      chk_all();
      rd(4);
      chk_all();
      wrb(15, 8'h05);
      chk_all();
      done("clamp");
   endtask : t_clamp

   task automatic t_decode();
      for (int i = 0; i < SW_W; i++) begin
         host.cycle(1'b1, BASE ^ (10'h020 << i), 16'h0fff, 1'b1, 8);
      end
      chk_all();
      st.build16 = 1'b0;
      host.cycle(1'b1, BASE + 10'h010, 16'h0abc, 1'b1, 8);
      chk_all();
      st.build16 = 1'b1;
      wrw(8, 12'habc);
      chk_all();
      done("decode");
   endtask : t_decode

   task automatic t_rst();
      do_reset();
      shown = '{default: SAFE_CODE};
      chk_all();
      wrb(15, 8'h0a);
      chk_all();
      done("reset");
   endtask : t_rst

   task automatic report_and_stop();
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      rst_n = 1'b0;
      st.sw_on = 5'b00111;
      st.build16 = 1'b1;
      shown = '{default: SAFE_CODE};
      do_reset();
      chk_all();
      done("power_up");
      t_fill();
      t_perch();
      t_clamp();
      t_decode();
      t_rst();
      report_and_stop();
   end
endmodule : testbench
